// File: hdl/spf_pkg.sv
// Constants, types and helpers for the serial port flag and interrupt block.
// Assumes a 32-bit APB slave port with byte addresses in the low 8 bits.
package spf_pkg;

  // Register byte offsets.
  localparam logic [7:0] SPF_OFS_STATUS = 8'h00;
  localparam logic [7:0] SPF_OFS_DATA = 8'h04;
  localparam logic [7:0] SPF_OFS_CTRL = 8'h08;
  localparam logic [7:0] SPF_OFS_EVT = 8'h0c;
  localparam logic [7:0] SPF_OFS_MASK = 8'h10;

  // Flag bit positions, shared by status, events and mask, and by enables except overrun; bit 0 is the nine-bit select in control.
  localparam int SPF_BIT_TXE = 7;
  localparam int SPF_BIT_DONE = 6;
  localparam int SPF_BIT_RXF = 5;
  localparam int SPF_BIT_IDLE = 4;
  localparam int SPF_BIT_OVR = 3;
  localparam int SPF_BIT_NINE = 0;

  // Writable bits and reset values.
  localparam logic [7:0] SPF_CTRL_WMASK = 8'hf1;
  localparam logic [7:0] SPF_FLAG_WMASK = 8'hf8;
  localparam logic [7:0] SPF_CTRL_RST = 8'h00;
  localparam logic [7:0] SPF_MASK_RST = 8'h00;
  localparam logic [7:0] SPF_FLAGS_RST = 8'hc0;

  // Run of ones on the receive input that marks an idle line.
  localparam logic [3:0] SPF_IDLE_ONES_8 = 4'ha;
  localparam logic [3:0] SPF_IDLE_ONES_9 = 4'hb;

  // The five flags as one carrier.
  typedef struct packed {
    logic txe;
    logic done;
    logic rxf;
    logic idle;
    logic ovr;
  } spf_flags_t;

  // APB answer carrier.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } spf_apb_rsp_t;

  // Places the flags at their status bit positions.
  function automatic logic [7:0] spf_flag_byte(input spf_flags_t f);
    logic [7:0] b;
    b = 8'h00;
    b[SPF_BIT_TXE] = f.txe;
    b[SPF_BIT_DONE] = f.done;
    b[SPF_BIT_RXF] = f.rxf;
    b[SPF_BIT_IDLE] = f.idle;
    b[SPF_BIT_OVR] = f.ovr;
    return b;
  endfunction : spf_flag_byte

endpackage : spf_pkg

// File: hdl/spf_flag_irq.sv
// Status flags, clear sequences and interrupt request of a serial port.
// Assumes a shifter and receiver on the same clock that report events as
// one-cycle strobes; only the receive pin itself is asynchronous.
//
// Notes on behaviour
// [R01] Enabled flags ORed onto one interrupt output.
// [R02] Byte taken by shifter sets transmit empty.
// [R03] Status read then data write clears empty.
// [R04] Done only after whole frame and empty queue.
// [R05] Break sends no stop bit, then done.
// [R06] Done when idle; transmit pin held high.
// [R07] Status read then data write clears done.
// [R08] Done clears itself once anything is queued.
// [R09] Frame moved to data register sets full.
// [R10] Status read then data read clears full.
// [R11] Unread data plus new frame: overrun, drop.
// [R12] Status read then data read clears overrun.
// [R13] Idle after ten or eleven ones received.
// [R14] Idle rearms only after a full flag set.
// [R15] Status read then data read clears idle.
// [R16] Status bits seven down to three fixed.
// [R17] Each flag gated by its own enable; overrun uses the full (RXF) enable.
// [R18] Status read arms; data access then clears.
module spf_flag_irq
  import spf_pkg::*;
(
  // Clock and asynchronous active-low reset.
  input wire logic clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit shifter side.
  input wire logic tx_take,
  input wire logic tx_active,
  input wire logic tx_special_req,
  input wire logic tx_line,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  output logic txd,
  // Receiver side.
  input wire logic rx_pin,
  input wire logic rx_bit_tick,
  input wire logic rx_frame_done,
  input wire logic [7:0] rx_frame_data,
  // Interrupt request toward the CPU.
  output logic irq
);

  logic rst_meta_q, rst_n;
  spf_apb_rsp_t rsp_q;
  logic acc, rd_acc, wr_acc, pready_d, mapped;
  logic [7:0] rd_byte;
  logic sts_rd, dat_wr, dat_rd, evt_wr;
  spf_flags_t flags_q, flags_d, arm_q;
  logic clr_txe, clr_done, clr_rxf, clr_ovr, clr_idle;
  logic done_set, rx_accept, rx_over, idle_set, idle_ok_q;
  logic [7:0] ctrl_q, mask_q, evt_q, rx_data_q, tx_data_q, en_byte;
  logic tx_valid_q, txd_q, irq_q;
  logic rx_meta_q, rx_sync_q;
  logic [3:0] ones_q, idle_thr;

  // Reset is released through two flops so every flop leaves it together.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // One wait state: pready rises on the second access cycle.
  assign pready_d = psel & penable & ~rsp_q.pready;
  assign acc = psel & penable & rsp_q.pready;
  assign rd_acc = acc & ~pwrite;
  assign wr_acc = acc & pwrite;
  assign sts_rd = rd_acc & (paddr == SPF_OFS_STATUS);
  assign dat_rd = rd_acc & (paddr == SPF_OFS_DATA);
  assign dat_wr = wr_acc & (paddr == SPF_OFS_DATA);
  assign evt_wr = wr_acc & (paddr == SPF_OFS_EVT);

  // Read mux; unmapped addresses read zero and answer with an error.
  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      SPF_OFS_STATUS: rd_byte = spf_flag_byte(flags_q); // R16
      SPF_OFS_DATA: rd_byte = rx_data_q;
      SPF_OFS_CTRL: rd_byte = ctrl_q;
      SPF_OFS_EVT: rd_byte = evt_q;
      SPF_OFS_MASK: rd_byte = mask_q;
      default: mapped = 1'b0;
    endcase
  end

  // Answer register; data and error stand only in the pready cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= pready_d;
      rsp_q.pslverr <= pready_d & ~mapped;
      rsp_q.prdata <= (pready_d & ~pwrite) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // Software-written control, mask and sticky event registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= SPF_CTRL_RST;
      mask_q <= SPF_MASK_RST;
      evt_q <= 8'h00;
    end else begin
      if (wr_acc && paddr == SPF_OFS_CTRL) begin
        ctrl_q <= pwdata[7:0] & SPF_CTRL_WMASK;
      end
      if (wr_acc && paddr == SPF_OFS_MASK) begin
        mask_q <= pwdata[7:0] & SPF_FLAG_WMASK;
      end
      // A new rising flag wins over a write-one-to-clear in the same cycle.
      evt_q <= (evt_q & ~(evt_wr ? pwdata[7:0] : 8'h00))
               | (spf_flag_byte(flags_d) & ~spf_flag_byte(flags_q));
    end
  end

  // Clear sequence: status read arms only the flags it saw set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= '0;
    end else if (sts_rd) begin
      arm_q <= flags_q; // R18
    end else begin
      if (dat_wr) begin
        arm_q.txe <= 1'b0;
        arm_q.done <= 1'b0;
      end
      if (dat_rd) begin
        arm_q.rxf <= 1'b0;
        arm_q.idle <= 1'b0;
        arm_q.ovr <= 1'b0;
      end
    end
  end

  assign clr_txe = dat_wr & arm_q.txe; // R03
  assign clr_done = dat_wr & arm_q.done; // R07
  assign clr_rxf = dat_rd & arm_q.rxf; // R10
  assign clr_ovr = dat_rd & arm_q.ovr; // R12
  assign clr_idle = dat_rd & arm_q.idle; // R15

  // Transmit holding byte; a write while full overwrites the queued byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      if (dat_wr) begin
        tx_data_q <= pwdata[7:0];
      end
      // A write in the take cycle is a new byte, so the set wins.
      if (dat_wr) begin
        tx_valid_q <= 1'b1;
      end else if (tx_take) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // The shifter keeps tx_active up through the stop bit, or through the
  // last break bit since a break has none, so done waits for both.
  assign done_set = flags_q.txe & ~tx_active & ~tx_valid_q
                    & ~tx_special_req; // R04 R05 R06

  // Receive acceptance: a frame finding unread data is dropped.
  assign rx_accept = rx_frame_done & (~flags_q.rxf | clr_rxf);
  assign rx_over = rx_frame_done & ~rx_accept; // R11

  // Next flag values; every set wins over a clear in the same cycle.
  always_comb begin
    flags_d = flags_q;
    if (tx_take) begin
      flags_d.txe = 1'b1; // R02
    end else if (clr_txe) begin
      flags_d.txe = 1'b0; // R03
    end
    if (done_set) begin
      flags_d.done = 1'b1; // R06
    end else if (clr_done || tx_valid_q || tx_special_req) begin
      flags_d.done = 1'b0; // R07 R08
    end
    if (rx_accept) begin
      flags_d.rxf = 1'b1; // R09
    end else if (clr_rxf) begin
      flags_d.rxf = 1'b0; // R10
    end
    if (rx_over) begin
      flags_d.ovr = 1'b1; // R11
    end else if (clr_ovr) begin
      flags_d.ovr = 1'b0; // R12
    end
    if (idle_set) begin
      flags_d.idle = 1'b1; // R13
    end else if (clr_idle) begin
      flags_d.idle = 1'b0; // R15
    end
  end

  // Flag register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= SPF_FLAGS_RST[SPF_BIT_TXE:SPF_BIT_OVR]; // Empty, done.
    end else begin
      flags_q <= flags_d;
    end
  end

  // Received byte stays untouched when an overrun drops a frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_q <= 8'h00;
    end else if (rx_accept) begin
      rx_data_q <= rx_frame_data; // R09 R11
    end
  end

  // Receive pin crosses in through two flops before the idle counter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Count ones at bit ticks; saturate so a long idle line cannot wrap.
  assign idle_thr = ctrl_q[SPF_BIT_NINE] ? SPF_IDLE_ONES_9
                    : SPF_IDLE_ONES_8; // R13
  assign idle_set = idle_ok_q & (ones_q >= idle_thr); // R13 R14

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_q <= 4'h0;
    end else if (rx_bit_tick) begin
      if (!rx_sync_q) begin
        ones_q <= 4'h0;
      end else if (ones_q != 4'hf) begin
        ones_q <= ones_q + 4'h1;
      end
    end
  end

  // Idle is reported once, then waits for a good frame to rearm.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ok_q <= 1'b1;
    end else if (rx_accept) begin
      idle_ok_q <= 1'b1; // R14
    end else if (idle_set) begin
      idle_ok_q <= 1'b0; // R14
    end
  end

  // Overrun rides on the receive enable as it has none of its own.
  always_comb begin
    en_byte = 8'h00;
    en_byte[SPF_BIT_TXE] = ctrl_q[SPF_BIT_TXE];
    en_byte[SPF_BIT_DONE] = ctrl_q[SPF_BIT_DONE];
    en_byte[SPF_BIT_RXF] = ctrl_q[SPF_BIT_RXF];
    en_byte[SPF_BIT_IDLE] = ctrl_q[SPF_BIT_IDLE];
    en_byte[SPF_BIT_OVR] = ctrl_q[SPF_BIT_RXF];
  end

  // Single level request and idle-high transmit pin, both registered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      irq_q <= (|(spf_flag_byte(flags_q) & en_byte)) // R01 R17
               | (|(evt_q & mask_q));
      txd_q <= flags_q.done | tx_line; // R06
    end
  end

  assign prdata = rsp_q.prdata;
  assign pready = rsp_q.pready;
  assign pslverr = rsp_q.pslverr;
  assign tx_data = tx_data_q;
  assign tx_data_valid = tx_valid_q;
  assign txd = txd_q;
  assign irq = irq_q;

  // Checks of the flag behaviour, all in the one clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_irq_or;
    (flags_q.rxf && ctrl_q[SPF_BIT_RXF]) |=> irq_q;
  endproperty
  a_irq_or: assert property (p_irq_or) // R01
    else $error("Enabled full flag did not raise irq.");

  property p_irq_gate;
    (evt_q == 8'h00 && (spf_flag_byte(flags_q) & en_byte) == 8'h00)
      |=> !irq_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R17
    else $error("Irq high with nothing enabled pending.");

  property p_take_sets;
    tx_take |=> flags_q.txe;
  endproperty
  a_take_sets: assert property (p_take_sets) // R02
    else $error("Taken byte did not set transmit empty.");

  property p_txe_clear;
    (dat_wr && arm_q.txe && !tx_take) |=> !flags_q.txe;
  endproperty
  a_txe_clear: assert property (p_txe_clear) // R03
    else $error("Transmit empty not cleared by sequence.");

  property p_done_busy;
    (tx_active || tx_valid_q) |=> !$rose(flags_q.done);
  endproperty
  a_done_busy: assert property (p_done_busy) // R04
    else $error("Done rose while frame still pending.");

  property p_done_pin;
    flags_q.done |=> txd_q;
  endproperty
  a_done_pin: assert property (p_done_pin) // R06
    else $error("Transmit pin not high while done.");

  property p_done_auto;
    dat_wr |-> ##2 !flags_q.done;
  endproperty
  a_done_auto: assert property (p_done_auto) // R08
    else $error("Done not cleared after data was queued.");

  property p_rx_load;
    (rx_frame_done && !flags_q.rxf) |=>
      (flags_q.rxf && rx_data_q == $past(rx_frame_data));
  endproperty
  a_rx_load: assert property (p_rx_load) // R09
    else $error("Received frame not loaded.");

  property p_rx_clear;
    (dat_rd && arm_q.rxf && !rx_frame_done) |=> !flags_q.rxf;
  endproperty
  a_rx_clear: assert property (p_rx_clear) // R10
    else $error("Full flag not cleared by sequence.");

  property p_overrun;
    (rx_frame_done && flags_q.rxf && !clr_rxf) |=>
      (flags_q.ovr && $stable(rx_data_q));
  endproperty
  a_overrun: assert property (p_overrun) // R11
    else $error("Overrun not flagged or data changed.");

  property p_idle_set;
    (idle_ok_q && ones_q >= idle_thr) |=> flags_q.idle;
  endproperty
  a_idle_set: assert property (p_idle_set) // R13
    else $error("Idle not set after run of ones.");

  property p_idle_nine;
    (idle_ok_q && !flags_q.idle && ctrl_q[SPF_BIT_NINE]
      && ones_q == SPF_IDLE_ONES_8) |=> !flags_q.idle;
  endproperty
  a_idle_nine: assert property (p_idle_nine) // R13
    else $error("Idle set after ten ones in nine-bit mode.");

  property p_idle_hold;
    !idle_ok_q |=> !$rose(flags_q.idle);
  endproperty
  a_idle_hold: assert property (p_idle_hold) // R14
    else $error("Idle rose before a frame rearmed it.");

  c_overrun: cover property (rx_frame_done && flags_q.rxf);
  c_idle: cover property ($rose(flags_q.idle));
  c_tx_cycle: cover property (dat_wr ##[1:50] $rose(flags_q.done));

endmodule : spf_flag_irq

// File: bench/spf_far_model.sv
// Far-side model of the transmit shifter and receiver for the flag block.
// Assumes the block's clock and reset; the bench steers reception.
module spf_far_model
  import spf_pkg::*;
#(
  parameter int FRAME = 40,
  parameter int TICK = 4
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Bench controls.
  input wire logic rx_go,
  input wire logic [7:0] rx_byte,
  input wire logic rx_high,
  input wire logic brk_req,
  // Transmit shifter side.
  input wire logic tx_data_valid,
  output logic tx_take,
  output logic tx_active,
  output logic tx_special_req,
  output logic tx_line,
  // Receiver side.
  output logic rx_pin,
  output logic rx_bit_tick,
  output logic rx_frame_done,
  output logic [7:0] rx_frame_data
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_cnt;
  int tick_cnt;
  logic start;

  // A queued byte is taken only while the shifter is free.
  assign start = tx_data_valid && !tx_active && !tx_take;
  // The line idles high between frames and toggles within one.
  assign tx_line = tx_active ? bit_cnt[1] : 1'h1;
  assign tx_special_req = brk_req; // A break request, steered by the bench.
  assign rx_pin = rx_high;

  // The shifter stays busy for FRAME cycles, stop bit included.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_take <= 1'h0;
      tx_active <= 1'h0;
      bit_cnt <= 0;
    end else begin
      tx_take <= start;
      tx_active <= start || bit_cnt > 1;
      bit_cnt <= start ? FRAME : (bit_cnt > 0 ? bit_cnt - 1 : 0);
    end
  end

  // Ticks run free; data lines carry junk outside a frame strobe so that
  // a design sampling them late cannot pass by luck.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 0;
      rx_bit_tick <= 1'h0;
      rx_frame_done <= 1'h0;
      rx_frame_data <= 8'h00;
    end else begin
      tick_cnt <= (tick_cnt == TICK - 1) ? 0 : tick_cnt + 1;
      rx_bit_tick <= tick_cnt == 0;
      rx_frame_done <= rx_go;
      rx_frame_data <= rx_go ? rx_byte : ~rx_frame_data;
    end
  end
endmodule : spf_far_model

// File: bench/spf_flag_irq_tb.sv
// Self-checking bench for the serial port flag and interrupt block.
// Assumes the far-side model drives the shifter and receiver ports.
module spf_flag_irq_tb
  import spf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
  end end

  logic clk = 1'h0;
  logic reset_n = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, last_err, irq, txd;
  logic tx_take, tx_active, tx_special_req, tx_line, tx_data_valid;
  logic [7:0] tx_data, rx_frame_data, rx_byte = 8'h00;
  logic rx_pin, rx_bit_tick, rx_frame_done, rx_go = 1'h0, rx_high = 1'h0;
  logic brk_req = 1'h0;
  int err_count = 0;
  int checked = 0;

  // A 25 ns clock.
  always #12.5 clk = ~clk;

  spf_flag_irq uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_take, .tx_active,
    .tx_special_req, .tx_line, .tx_data, .tx_data_valid, .txd, .rx_pin,
    .rx_bit_tick, .rx_frame_done, .rx_frame_data, .irq);

  spf_far_model far (.clk, .reset_n, .rx_go, .rx_byte, .rx_high, .brk_req,
    .tx_data_valid, .tx_take, .tx_active, .tx_special_req, .tx_line,
    .rx_pin, .rx_bit_tick, .rx_frame_done, .rx_frame_data);

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One APB transfer, held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rdata, {24'h0, e})
  endtask : rd

  // The interrupt is registered, so it is looked at two edges later.
  task automatic irq_is(input logic e);
    tick(2);
    `CHK(irq, e)
  endtask : irq_is

  // One received frame handed over by the model; the model registers the
  // strobe, so the task returns at the edge at which the block takes it.
  task automatic frame(input logic [7:0] b);
    @(posedge clk);
    rx_go <= 1'h1;
    rx_byte <= b;
    @(posedge clk);
    rx_go <= 1'h0;
    @(posedge clk);
  endtask : frame

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Main sequence: reset, registers, transmit, receive, events, idle.
  initial begin
    reset_n = 1'h0;
    tick(3);
    reset_n <= 1'h1;
    tick(3);
    `CHK(txd, 1'h1)
    `CHK(irq, 1'h0)
    rd(SPF_OFS_STATUS, 8'hc0);
    rd(SPF_OFS_CTRL, SPF_CTRL_RST);
    rd(SPF_OFS_MASK, SPF_MASK_RST);
    rd(8'h14, 8'h00);
    `CHK(last_err, 1'h1)
    for (int i = 4; i < 8; i++) begin
      wr(SPF_OFS_CTRL, 8'h01 << i);
      irq_is(i > 5);
    end
    wr(SPF_OFS_CTRL, 8'h00);
    // Second byte is queued while the first still shifts.
    wr(SPF_OFS_DATA, 8'h5a);
    tick(2);
    `CHK(tx_data, 8'h5a)
    `CHK(tx_data_valid, 1'h1)
    rd(SPF_OFS_STATUS, 8'h80);
    wr(SPF_OFS_DATA, 8'ha5);
    rd(SPF_OFS_STATUS, 8'h00);
    tick(50);
    rd(SPF_OFS_STATUS, 8'h80);
    tick(40);
    rd(SPF_OFS_STATUS, 8'hc0);
    `CHK(txd, 1'h1)
    // A queued break drops done; done returns once it has gone out.
    brk_req <= 1'h1;
    rd(SPF_OFS_STATUS, 8'h80);
    brk_req <= 1'h0;
    rd(SPF_OFS_STATUS, 8'hc0);
    frame(8'h3c);
    rd(SPF_OFS_STATUS, 8'he0);
    frame(8'h99);
    rd(SPF_OFS_STATUS, 8'he8);
    rd(SPF_OFS_DATA, 8'h3c);
    rd(SPF_OFS_STATUS, 8'hc0);
    frame(8'h11);
    rd(SPF_OFS_DATA, 8'h11);
    rd(SPF_OFS_STATUS, 8'he0);
    rd(SPF_OFS_DATA, 8'h11);
    rd(SPF_OFS_STATUS, 8'hc0);
    wr(SPF_OFS_EVT, 8'hf8);
    rd(SPF_OFS_EVT, 8'h00);
    wr(SPF_OFS_MASK, 8'h20);
    rd(SPF_OFS_MASK, 8'h20);
    frame(8'h42);
    irq_is(1'h1);
    rd(SPF_OFS_EVT, 8'h20);
    wr(SPF_OFS_EVT, 8'h20);
    irq_is(1'h0);
    rd(SPF_OFS_STATUS, 8'he0);
    rd(SPF_OFS_DATA, 8'h42);
    // Nine-bit select: idle needs eleven ones here.
    wr(SPF_OFS_CTRL, 8'h01);
    rx_high <= 1'h1;
    tick(70);
    rd(SPF_OFS_STATUS, 8'hd0);
    wr(SPF_OFS_CTRL, 8'h10);
    irq_is(1'h1);
    rd(SPF_OFS_DATA, 8'h42);
    rd(SPF_OFS_STATUS, 8'hc0);
    tick(70);
    rd(SPF_OFS_STATUS, 8'hc0);
    frame(8'h07);
    rd(SPF_OFS_STATUS, 8'hf0);
    conclude;
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    tick(3000);
    err_count++;
    conclude;
  end
endmodule : spf_flag_irq_tb
